// ==== verilog/adps_params.svh ====
/*
 * Addresses, reset values and field constants of the analog/digital port select block.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef ADPS_PARAMS_SVH
`define ADPS_PARAMS_SVH

`define ADPS_CFG_ADDR 16'hFF8F
`define ADPS_SEG_ADDR 16'hFFB5
`define ADPS_CFG_RESET 8'h08
`define ADPS_SEG_RESET 8'h00
`define ADPS_CFG_FIELD_MSB 3
`define ADPS_CFG_FIELD_ZERO 4'h0
`define ADPS_CFG_ALL_ANALOG 4'h0
`define ADPS_CFG_SAR_ONLY_FIRST 4'h5
`define ADPS_CFG_ALL_DIGITAL 4'h8
`define ADPS_ALL_PINS 8'hFF
`define ADPS_NO_PINS 8'h00
`define ADPS_ONE_HOT_BASE 8'h01
`define ADPS_READ_IDLE 8'h00

`endif

// ==== verilog/adps_pkg.sv ====
/*
 * Types shared by the analog/digital port select block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adps_pkg;

	typedef enum logic [0:0] {
		ADPS_IDLE = 1'b0,
		ADPS_WAIT = 1'b1
	} adps_state_e;

	typedef logic [7:0] adps_byte_t;

endpackage

// ==== verilog/adps_pin_decode.sv ====
/*
 * Combinational decode of the pin selection field into per-pin analog masks.
 * Assumes the field value comes from the configuration register of the top module.
 */
`timescale 1ns/1ps
`include "adps_params.svh"

module adps_pin_decode #(
	parameter int PINS = 8
) (
	input wire logic [`ADPS_CFG_FIELD_MSB:0] field,
	output logic [PINS-1:0] analog_mask,
	output logic [PINS-1:0] delta_sigma_ok
);

	// pins at and above the field value are analog; 5..7 keep top pins for the sar converter only
	function automatic logic [PINS-1:0] analog_of(input logic [`ADPS_CFG_FIELD_MSB:0] f);
		logic [PINS-1:0] m;
		m = '0;
		if (f <= `ADPS_CFG_ALL_DIGITAL) begin
			m = {PINS{1'b1}} << f;
		end
		// prohibited codes fall back to all digital so no pad is left floating
		return m;
	endfunction

	always_comb begin
		analog_mask = analog_of(field);
		delta_sigma_ok = (field < `ADPS_CFG_SAR_ONLY_FIRST) ? analog_mask : '0;
	end

endmodule // adps_pin_decode

// ==== verilog/adps_port_select.sv ====
/*
 * Analog/digital pin selection for the eight shared port-2 pins, with its two
 * special function registers, the write wait cycle and the segment override.
 * Assumes a cpu access port synchronous to clock that holds a write while
 * sfr_wait is high, and port-2 logic that supplies output data and direction.
 */
// Contract
// - field 0 makes all pins analog, 1..4 make the lowest 1..4 digital, 5..7 leave top 3..1 analog for sar only, 8 all digital, others prohibited.
// - the configuration register is 8 bits, field in bits 3..0, bits 7..4 always zero.
// - reset loads the configuration register with 08h so all pins are digital.
// - the configuration register takes bit writes and byte writes, a bit write touching only its bit.
// - every configuration write inserts one wait cycle before it completes.
// - a pin selected for segment output drives segment data whatever the configuration says.
// - port 2 is an 8-bit per-bit-direction port that leaves reset as digital input.
`timescale 1ns/1ps
`include "adps_params.svh"

module adps_port_select #(
	parameter int PINS = 8
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [15:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic sfr_bit_op,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic sfr_bit_val,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_wait,
	input wire logic [PINS-1:0] port_out,
	input wire logic [PINS-1:0] port_two_direction,
	input wire logic [PINS-1:0] seg_data,
	input wire logic [PINS-1:0] pad_in,
	output logic [PINS-1:0] pad_out,
	output logic [PINS-1:0] pad_oe,
	output logic [PINS-1:0] pad_ie,
	output logic [PINS-1:0] port_in,
	output logic [PINS-1:0] sar_channel_en,
	output logic [PINS-1:0] delta_sigma_channel_en
);

	adps_pkg::adps_state_e state_q, state_d;
	adps_pkg::adps_byte_t cfg_q, cfg_d;
	adps_pkg::adps_byte_t pend_q, pend_d;
	adps_pkg::adps_byte_t seg_q, seg_d;
	adps_pkg::adps_byte_t rdata_q, rdata_d;
	logic wait_q, wait_d;
	logic [PINS-1:0] amask;
	logic [PINS-1:0] ds_ok;
	logic [PINS-1:0] pad_out_q, pad_out_d;
	logic [PINS-1:0] pad_oe_q, pad_oe_d;
	logic [PINS-1:0] pad_ie_q, pad_ie_d;
	logic [PINS-1:0] port_in_q, port_in_d;
	logic [PINS-1:0] sar_q, sar_d;
	logic [PINS-1:0] ds_q, ds_d;
	logic cfg_hit;
	logic seg_hit;

	// bit operation or whole byte, applied to the current value
	function automatic adps_pkg::adps_byte_t merge(input adps_pkg::adps_byte_t cur, input logic bit_op,
			input logic [2:0] sel, input logic val, input adps_pkg::adps_byte_t wdata);
		adps_pkg::adps_byte_t r;
		r = wdata;
		if (bit_op) begin
			r = cur;
			r[sel] = val;
		end
		return r;
	endfunction

	assign cfg_hit = (sfr_addr == `ADPS_CFG_ADDR);
	assign seg_hit = (sfr_addr == `ADPS_SEG_ADDR);

	adps_pin_decode #(
		.PINS(PINS)
	) u_decode (
		.field(cfg_q[`ADPS_CFG_FIELD_MSB:0]),
		.analog_mask(amask),
		.delta_sigma_ok(ds_ok)
	);

	// register access and the configuration write wait
	always_comb begin
		state_d = state_q;
		cfg_d = cfg_q;
		pend_d = pend_q;
		seg_d = seg_q;
		wait_d = 1'b0;
		rdata_d = `ADPS_READ_IDLE;
		unique case (state_q)
			adps_pkg::ADPS_IDLE: begin
				if (sfr_wr && cfg_hit) begin
					// commit is deferred one cycle so the cpu sees the wait first
					pend_d = merge(cfg_q, sfr_bit_op, sfr_bit_sel, sfr_bit_val, sfr_wdata);
					pend_d[7:`ADPS_CFG_FIELD_MSB+1] = `ADPS_CFG_FIELD_ZERO;
					wait_d = 1'b1;
					state_d = adps_pkg::ADPS_WAIT;
				end else if (sfr_wr && seg_hit) begin
					seg_d = merge(seg_q, sfr_bit_op, sfr_bit_sel, sfr_bit_val, sfr_wdata);
				end
				if (sfr_rd && cfg_hit) begin
					rdata_d = cfg_q;
				end else if (sfr_rd && seg_hit) begin
					rdata_d = seg_q;
				end
			end
			adps_pkg::ADPS_WAIT: begin
				// held request is ignored here; the write completes as wait drops
				cfg_d = pend_q;
				state_d = adps_pkg::ADPS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= adps_pkg::ADPS_IDLE;
			cfg_q <= `ADPS_CFG_RESET;
			pend_q <= `ADPS_CFG_RESET;
			seg_q <= `ADPS_SEG_RESET;
			wait_q <= 1'b0;
			rdata_q <= `ADPS_READ_IDLE;
		end else begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			pend_q <= pend_d;
			seg_q <= seg_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// per-pin routing; segment select overrides the analog field
	always_comb begin
		sar_d = amask & ~seg_q;
		ds_d = ds_ok & ~seg_q;
		pad_ie_d = ~amask & ~seg_q;
		// direction bit high means input; analog pins have the driver gated off whatever the direction bit says
		pad_oe_d = seg_q | (~amask & ~port_two_direction);
		pad_out_d = (seg_q & seg_data) | (~seg_q & ~amask & port_out);
		port_in_d = pad_in & pad_ie_q;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sar_q <= `ADPS_NO_PINS;
			ds_q <= `ADPS_NO_PINS;
			pad_ie_q <= `ADPS_ALL_PINS;
			pad_oe_q <= `ADPS_NO_PINS;
			pad_out_q <= `ADPS_NO_PINS;
			port_in_q <= `ADPS_NO_PINS;
		end else begin
			sar_q <= sar_d;
			ds_q <= ds_d;
			pad_ie_q <= pad_ie_d;
			pad_oe_q <= pad_oe_d;
			pad_out_q <= pad_out_d;
			port_in_q <= port_in_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign sfr_wait = wait_q;
	assign pad_out = pad_out_q;
	assign pad_oe = pad_oe_q;
	assign pad_ie = pad_ie_q;
	assign port_in = port_in_q;
	assign sar_channel_en = sar_q;
	assign delta_sigma_channel_en = ds_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence cfg_write_taken;
		state_q == adps_pkg::ADPS_IDLE && sfr_wr && cfg_hit;
	endsequence

	sequence wait_then_release;
		wait_q ##1 !wait_q;
	endsequence

	a_wait_one_cycle: assert property (cfg_write_taken |=> wait_then_release)
		else $error("config write did not give exactly one wait cycle");

	a_cfg_commit_late: assert property (cfg_write_taken |=> cfg_q == $past(cfg_q) ##1 cfg_q == $past(pend_q))
		else $error("config write committed at the wrong cycle");

	a_cfg_upper_zero: assert property (cfg_q[7:4] == `ADPS_CFG_FIELD_ZERO)
		else $error("config upper bits not zero");

	a_all_digital_field: assert property ((cfg_q[3:0] == `ADPS_CFG_ALL_DIGITAL && seg_q == `ADPS_NO_PINS)
			|=> pad_ie_q == `ADPS_ALL_PINS && sar_q == `ADPS_NO_PINS)
		else $error("all-digital setting left a pin analog");

	a_all_analog_field: assert property (cfg_q[3:0] == `ADPS_CFG_ALL_ANALOG |=> sar_q == ~$past(seg_q))
		else $error("all-analog setting left a pin digital");

	a_sar_only_field: assert property ((cfg_q[3:0] >= `ADPS_CFG_SAR_ONLY_FIRST && cfg_q[3:0] < `ADPS_CFG_ALL_DIGITAL)
			|=> ds_q == `ADPS_NO_PINS && sar_q != `ADPS_NO_PINS || $past(seg_q) != `ADPS_NO_PINS)
		else $error("sar-only setting exposed a delta-sigma channel");

	a_segment_wins: assert property (1'b1 |=> ($past(seg_q) & ~pad_oe_q) == `ADPS_NO_PINS
			&& ($past(seg_q) & sar_q) == `ADPS_NO_PINS)
		else $error("segment pin not driving segment output");

	a_analog_no_drive: assert property ((sar_q & (pad_oe_q | pad_ie_q)) == `ADPS_NO_PINS)
		else $error("analog pin has digital path enabled");

	a_seg_bit_write: assert property ((state_q == adps_pkg::ADPS_IDLE && sfr_wr && seg_hit && sfr_bit_op)
			|=> ((seg_q ^ $past(seg_q)) & ~(`ADPS_ONE_HOT_BASE << $past(sfr_bit_sel))) == `ADPS_NO_PINS)
		else $error("bit write changed another bit");

	a_digital_direction: assert property (1'b1 |=> (pad_oe_q & ~$past(seg_q))
			== (~$past(port_two_direction) & ~$past(amask) & ~$past(seg_q)))
		else $error("digital pin driver does not follow direction");

endmodule // adps_port_select

// ==== tb/adps_pad_model.sv ====
/*
 * Pad model for the eight shared pins: resolves each pin from the block's driver and an outside source.
 * Assumes the bench holds the outside level and wires pad_in back into the block.
 */
`timescale 1ns/1ps

module adps_pad_model #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0] pad_out,
	input wire logic [PINS-1:0] pad_oe,
	input wire logic [PINS-1:0] ext_level,
	output logic [PINS-1:0] pad_in
);
	// an undriven pin shows the outside source, never the last value the block drove
	assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule // adps_pad_model

// ==== tb/analog_digital_port_select_bench.sv ====
/*
 * Self-checking bench of the analog/digital port select block, with register tasks and pin checks.
 * Assumes the design files and the pad model are compiled before it.
 */
`timescale 1ns/1ps
`include "adps_params.svh"

module analog_digital_port_select_bench;
	logic clock, sys_rst, sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_val, sfr_wait;
	logic [15:0] sfr_addr;
	logic [2:0] sfr_bit_sel;
	logic [7:0] sfr_wdata, sfr_rdata, port_out, port_two_direction, seg_data, pad_in, pad_out, pad_oe;
	logic [7:0] pad_ie, port_in, sar_channel_en, delta_sigma_channel_en, ext_level, e;
	int error_cnt, comparisons;

	adps_port_select #(.PINS(8)) adps_port_select_i (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_op(sfr_bit_op), .sfr_bit_sel(sfr_bit_sel),
		.sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_wait(sfr_wait),
		.port_out(port_out), .port_two_direction(port_two_direction), .seg_data(seg_data), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie), .port_in(port_in),
		.sar_channel_en(sar_channel_en), .delta_sigma_channel_en(delta_sigma_channel_en));

	adps_pad_model #(.PINS(8)) adps_pad_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
		.pad_in(pad_in));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic finish_test;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		comparisons++;
		if (g !== x) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask

	// a config write is held through its wait cycle and dropped when the wait ends
	task automatic wr(input logic [15:0] a, input logic b, input logic [2:0] s, input logic v, input logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_bit_op <= b;
		sfr_bit_sel <= s;
		sfr_bit_val <= v;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clock);
		if (a != `ADPS_CFG_ADDR) sfr_wr <= 1'b0;
		#1;
		chk("sfr_wait", {7'h00, a == `ADPS_CFG_ADDR}, {7'h00, sfr_wait});
		if (a == `ADPS_CFG_ADDR) begin
			@(posedge clock);
			sfr_wr <= 1'b0;
		end
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] x);
		@(posedge clock);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clock);
		sfr_rd <= 1'b0;
		#1;
		chk("sfr_rdata", x, sfr_rdata);
	endtask

	// two register stages lie between a committed write and port_in
	task automatic pins(input logic [7:0] sar, input logic [7:0] ds, input logic [7:0] ie, input logic [7:0] oe);
		repeat (3) @(posedge clock);
		#1;
		chk("sar_channel_en", sar, sar_channel_en);
		chk("delta_sigma_channel_en", ds, delta_sigma_channel_en);
		chk("pad_ie", ie, pad_ie);
		chk("pad_oe", oe, pad_oe);
	endtask

	initial begin
		repeat (3000) @(posedge clock);
		error_cnt++;
		finish_test();
	end

	initial begin
		{sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_val, sfr_addr, sfr_bit_sel, sfr_wdata} = '0;
		{port_out, seg_data, ext_level} = '0;
		port_two_direction = 8'hFF;
		error_cnt = 0;
		comparisons = 0;
		sys_rst = 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		pins(8'h00, 8'h00, 8'hFF, 8'h00);
		rd(`ADPS_CFG_ADDR, 8'h08);
		rd(`ADPS_SEG_ADDR, 8'h00);
		for (int c = 0; c <= 8; c++) begin
			e = 8'hFF << c;
			wr(`ADPS_CFG_ADDR, 1'b0, 3'h0, 1'b0, 8'(c));
			pins(e, (c <= 4) ? e : 8'h00, ~e, 8'h00);
			rd(`ADPS_CFG_ADDR, 8'(c));
		end
		ext_level <= 8'hA5;
		wr(`ADPS_CFG_ADDR, 1'b0, 3'h0, 1'b0, 8'h04);
		pins(8'hF0, 8'hF0, 8'h0F, 8'h00);
		chk("port_in", 8'h05, port_in);
		wr(`ADPS_CFG_ADDR, 1'b0, 3'h0, 1'b0, 8'hF3);
		rd(`ADPS_CFG_ADDR, 8'h03);
		wr(`ADPS_CFG_ADDR, 1'b0, 3'h0, 1'b0, 8'h08);
		wr(`ADPS_CFG_ADDR, 1'b1, 3'h0, 1'b1, 8'h00);
		rd(`ADPS_CFG_ADDR, 8'h09);
		pins(8'h00, 8'h00, 8'hFF, 8'h00);
		wr(`ADPS_CFG_ADDR, 1'b1, 3'h3, 1'b0, 8'hFF);
		rd(`ADPS_CFG_ADDR, 8'h01);
		wr(`ADPS_CFG_ADDR, 1'b1, 3'h7, 1'b1, 8'h00);
		rd(`ADPS_CFG_ADDR, 8'h01);
		port_two_direction <= 8'h0F;
		port_out <= 8'h3C;
		wr(`ADPS_CFG_ADDR, 1'b0, 3'h0, 1'b0, 8'h08);
		pins(8'h00, 8'h00, 8'hFF, 8'hF0);
		chk("pad_out", 8'h3C, pad_out);
		chk("port_in", 8'h35, port_in);
		port_two_direction <= 8'hFF;
		seg_data <= 8'hA5;
		wr(`ADPS_CFG_ADDR, 1'b0, 3'h0, 1'b0, 8'h00);
		wr(`ADPS_SEG_ADDR, 1'b0, 3'h0, 1'b0, 8'hF0);
		pins(8'h0F, 8'h0F, 8'h00, 8'hF0);
		chk("pad_out", 8'hA0, pad_out & 8'hF0);
		rd(`ADPS_SEG_ADDR, 8'hF0);
		wr(16'hFF90, 1'b0, 3'h0, 1'b0, 8'h55);
		rd(16'hFF90, 8'h00);
		rd(`ADPS_CFG_ADDR, 8'h00);
		wr(`ADPS_SEG_ADDR, 1'b1, 3'h1, 1'b1, 8'h00);
		rd(`ADPS_SEG_ADDR, 8'hF2);
		wr(`ADPS_CFG_ADDR, 1'b1, 3'h2, 1'b1, 8'h00);
		rd(`ADPS_CFG_ADDR, 8'h04);
		// second reset mid-run must restore both registers after writes
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		pins(8'h00, 8'h00, 8'hFF, 8'h00);
		rd(`ADPS_CFG_ADDR, 8'h08);
		rd(`ADPS_SEG_ADDR, 8'h00);
		finish_test();
	end
endmodule // analog_digital_port_select_bench
